// File: rtl/trc_pkg.sv
package trc_pkg;

  // decoding mode codes, units digit of the terminal command mode setting
  localparam logic [3:0] MODE_TWO_LINE_1 = 4'h0;
  localparam logic [3:0] MODE_TWO_LINE_2 = 4'h1;
  localparam logic [3:0] MODE_THREE_LINE_1 = 4'h2;
  localparam logic [3:0] MODE_THREE_LINE_2 = 4'h3;
  localparam logic [3:0] MODE_TWO_LINE_PRIO = 4'h4;
  localparam logic [3:0] MODE_THREE_LINE_3 = 4'h5;

  // terminal bit positions inside the synchronised vector
  localparam int TERM_FIRST = 0;
  localparam int TERM_SECOND = 1;
  localparam int TERM_ENABLE = 2;
  localparam int TERM_COUNT = 3;

  // reset values
  localparam logic [2:0] SYNC_RESET = 3'h0;
  // previous samples start high so a terminal must be seen low before it can rise
  localparam logic [2:0] PREV_RESET = 3'h7;
  localparam logic [3:0] MODE_RESET = 4'h0;

  // flip-flop stages from a pin to the synchronised vector
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    TRC_STOP = 2'b00,
    TRC_FORWARD = 2'b01,
    TRC_REVERSE = 2'b10
  } trc_run_e;

endpackage

// File: rtl/trc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module trc_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_sync
);

  logic [2:0] stage_one;

  // two flip-flops per terminal; stage_one feeds only the second flop
  genvar i;
  generate
    for (i = 0; i < trc_pkg::TERM_COUNT; i = i + 1) begin : g_bit
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          stage_one[i] <= trc_pkg::SYNC_RESET[i];
          pin_sync[i] <= trc_pkg::SYNC_RESET[i];
        end else begin
          stage_one[i] <= pin_in[i];
          pin_sync[i] <= stage_one[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// File: rtl/trc_decoder.sv
// Summary of operation
// R1 - units digit of mode setting picks one of six decoding modes, codes 0 to 5.
// R2 - mode 2: first terminal edge runs forward, second edge reverse; latest edge wins.
// R3 - mode 2: first and second terminals are edge inputs, enable is a level.
// R4 - any three-line mode: enable low forces stop whatever the other terminals do.
// R5 - outside party raises enable before any run edge; edges without enable are ignored.
// R6 - mode 3: first terminal edge runs; second terminal level gives direction, high reverse.
// R7 - mode 3: only first terminal edge-triggered; direction and enable are levels.
// R8 - mode 4: levels decode stop/forward/reverse; with both on, the earlier one holds.
// R9 - mode 4: both command terminals are sampled as levels, not edges.
// R10 - mode 5: edges start forward or reverse; edge ignored while the other is asserted.
// R11 - terminals synchronised; rise is low sample then high sample; reset gives stop.
`timescale 1ns/1ps
`default_nettype none

module trc_decoder (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic first_command_terminal,
  input wire logic second_command_terminal,
  input wire logic enable_terminal,
  input wire logic [3:0] terminal_command_mode_setting,
  output logic forward_run_command,
  output logic reverse_run_command
);

  logic [2:0] term_sync;
  logic [2:0] term_prev;
  logic [2:0] term_rise;
  logic [3:0] mode;
  logic first_lvl;
  logic second_lvl;
  logic enable_lvl;
  logic first_rise;
  logic second_rise;
  trc_pkg::trc_run_e run_state;
  trc_pkg::trc_run_e next_run_state;
  trc_pkg::trc_run_e next_two_line_1;
  trc_pkg::trc_run_e next_two_line_2;
  trc_pkg::trc_run_e next_three_line_1;
  trc_pkg::trc_run_e next_three_line_2;
  trc_pkg::trc_run_e next_two_line_prio;
  trc_pkg::trc_run_e next_three_line_3;
  logic three_line_mode;
  logic mode_changed;
  logic [1:0] warm_cnt;
  logic sync_ready;

  // R11 synchronise terminals
  trc_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pin_in({enable_terminal, second_command_terminal, first_command_terminal}),
    .pin_sync(term_sync)
  );

  // R11 history held at all-ones until the synchroniser carries real samples
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      warm_cnt <= 2'h0;
    end else if (!sync_ready) begin
      warm_cnt <= warm_cnt + 2'h1;
    end
  end

  assign sync_ready = warm_cnt == 2'(trc_pkg::SYNC_STAGES);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      term_prev <= trc_pkg::PREV_RESET;
    end else if (!sync_ready) begin
      term_prev <= trc_pkg::PREV_RESET;
    end else begin
      term_prev <= term_sync;
    end
  end

  // R11 rising edge detect
  assign term_rise = term_sync & ~term_prev;

  assign first_lvl = term_sync[trc_pkg::TERM_FIRST];
  assign second_lvl = term_sync[trc_pkg::TERM_SECOND];
  assign enable_lvl = term_sync[trc_pkg::TERM_ENABLE];
  assign first_rise = term_rise[trc_pkg::TERM_FIRST];
  assign second_rise = term_rise[trc_pkg::TERM_SECOND];

  // mode change forces stop for one cycle; edge modes 2, 3 and 5 then stay stopped until a new edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode <= trc_pkg::MODE_RESET;
    end else begin
      mode <= terminal_command_mode_setting;
    end
  end

  // setting differs from the registered copy
  assign mode_changed = terminal_command_mode_setting != mode;

  // R4 modes that carry an enable terminal
  always_comb begin
    three_line_mode = 1'b0;
    if (terminal_command_mode_setting == trc_pkg::MODE_THREE_LINE_1) begin
      three_line_mode = 1'b1;
    end else if (terminal_command_mode_setting == trc_pkg::MODE_THREE_LINE_2) begin
      three_line_mode = 1'b1;
    end else if (terminal_command_mode_setting == trc_pkg::MODE_THREE_LINE_3) begin
      three_line_mode = 1'b1;
    end
  end

  // two-line mode 1: both or neither terminal stops
  always_comb begin
    next_two_line_1 = trc_pkg::TRC_STOP;
    if (first_lvl && !second_lvl) begin
      next_two_line_1 = trc_pkg::TRC_FORWARD;
    end else if (!first_lvl && second_lvl) begin
      next_two_line_1 = trc_pkg::TRC_REVERSE;
    end
  end

  // two-line mode 2: first terminal runs, second picks reverse
  always_comb begin
    next_two_line_2 = trc_pkg::TRC_STOP;
    if (first_lvl && second_lvl) begin
      next_two_line_2 = trc_pkg::TRC_REVERSE;
    end else if (first_lvl) begin
      next_two_line_2 = trc_pkg::TRC_FORWARD;
    end
  end

  // R2 R3 latest edge sets direction; simultaneous edges hold
  always_comb begin
    next_three_line_1 = run_state;
    if (first_rise && !second_rise) begin
      next_three_line_1 = trc_pkg::TRC_FORWARD;
    end else if (second_rise && !first_rise) begin
      next_three_line_1 = trc_pkg::TRC_REVERSE;
    end
  end

  // R6 R7 edge runs, level steers
  always_comb begin
    next_three_line_2 = run_state;
    if (first_rise || run_state != trc_pkg::TRC_STOP) begin
      next_three_line_2 = second_lvl ? trc_pkg::TRC_REVERSE : trc_pkg::TRC_FORWARD;
    end
  end

  // R8 R9 level decode, earlier terminal keeps priority
  always_comb begin
    next_two_line_prio = run_state;
    if (first_lvl && !second_lvl) begin
      next_two_line_prio = trc_pkg::TRC_FORWARD;
    end else if (!first_lvl && second_lvl) begin
      next_two_line_prio = trc_pkg::TRC_REVERSE;
    end else if (!first_lvl && !second_lvl) begin
      next_two_line_prio = trc_pkg::TRC_STOP;
    end
  end

  // R10 edge locked out while other terminal held
  always_comb begin
    next_three_line_3 = run_state;
    if (first_rise && !second_lvl) begin
      next_three_line_3 = trc_pkg::TRC_FORWARD;
    end else if (second_rise && !first_lvl) begin
      next_three_line_3 = trc_pkg::TRC_REVERSE;
    end
  end

  always_comb begin
    next_run_state = trc_pkg::TRC_STOP;
    // R1 mode select
    case (terminal_command_mode_setting)
      trc_pkg::MODE_TWO_LINE_1: begin
        next_run_state = next_two_line_1;
      end
      trc_pkg::MODE_TWO_LINE_2: begin
        next_run_state = next_two_line_2;
      end
      trc_pkg::MODE_THREE_LINE_1: begin
        next_run_state = next_three_line_1;
      end
      trc_pkg::MODE_THREE_LINE_2: begin
        next_run_state = next_three_line_2;
      end
      trc_pkg::MODE_TWO_LINE_PRIO: begin
        next_run_state = next_two_line_prio;
      end
      trc_pkg::MODE_THREE_LINE_3: begin
        next_run_state = next_three_line_3;
      end
      default: begin
        next_run_state = trc_pkg::TRC_STOP;
      end
    endcase
    // R4 enable low stops
    if (three_line_mode && !enable_lvl) begin
      next_run_state = trc_pkg::TRC_STOP;
    end
    if (mode_changed) begin
      next_run_state = trc_pkg::TRC_STOP;
    end
  end

  // R11 reset to stop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_state <= trc_pkg::TRC_STOP;
    end else begin
      run_state <= next_run_state;
    end
  end

  // outputs from flops, never both high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      forward_run_command <= 1'b0;
      reverse_run_command <= 1'b0;
    end else begin
      forward_run_command <= next_run_state == trc_pkg::TRC_FORWARD;
      reverse_run_command <= next_run_state == trc_pkg::TRC_REVERSE;
    end
  end

endmodule

`default_nettype wire

// File: verification/trc_decoder_chk.sv
`timescale 1ns/1ps
`default_nettype none
module trc_decoder_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic first_command_terminal,
  input wire logic second_command_terminal,
  input wire logic enable_terminal,
  input wire logic [3:0] terminal_command_mode_setting,
  input wire logic forward_run_command,
  input wire logic reverse_run_command
);
  wire f = first_command_terminal;
  wire s = second_command_terminal;
  wire en = enable_terminal;
  wire [3:0] m = terminal_command_mode_setting;
  wire fw = forward_run_command;
  wire rv = reverse_run_command;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_reset_stop: assert property ($rose(reset_n) |-> (!fw && !rv)[*2])
    else $error("run after reset");
  a_enable_stop: assert property ((!en && m inside {4'h2, 4'h3, 4'h5})[*3] |=> !fw && !rv)
    else $error("run without enable");
  a_bad_mode: assert property ((m > 4'h5)[*2] |=> !fw && !rv)
    else $error("run in unused mode");
  a_prio_hold: assert property ((m == 4'h4 && f && s)[*3] ##0 fw |=> fw)
    else $error("earlier terminal lost");
  a_prio_rev: assert property ((m == 4'h4 && !f && s)[*3] |=> rv && !fw)
    else $error("level reverse missing");
  a_level_dir: assert property ((m == 4'h3 && en && s)[*3] ##0 (fw || rv) |=> rv)
    else $error("direction level ignored");
  a_edge_fwd: assert property ((m == 4'h2 && en && !s)[*2] ##0 $rose(f) ##1
    (m == 4'h2 && en && !s && f)[*2] |=> fw) else $error("forward edge missed");
  a_edge_block: assert property ((m == 4'h5 && en && f && !rv)[*3] |=> !rv)
    else $error("blocked edge taken");
endmodule
bind trc_decoder trc_decoder_chk i_trc_decoder_chk (.clk(clk), .reset_n(reset_n),
  .first_command_terminal(first_command_terminal),
  .second_command_terminal(second_command_terminal), .enable_terminal(enable_terminal),
  .terminal_command_mode_setting(terminal_command_mode_setting),
  .forward_run_command(forward_run_command), .reverse_run_command(reverse_run_command));
`default_nettype wire

// File: verification/trc_btn.sv
`timescale 1ns/1ps
`default_nettype none
module trc_btn (
  input wire logic clk,
  input wire logic [2:0] press,
  output logic [2:0] pins = 3'h0
);
  always @(posedge clk) pins <= #5 press;
endmodule
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] mode = 4'h0;
  logic [2:0] press = 3'h0;
  logic [2:0] pins;
  logic fw, rv;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  trc_btn i_trc_btn (.clk(clk), .press(press), .pins(pins));
  trc_decoder i_trc_decoder (.clk(clk), .reset_n(reset_n), .first_command_terminal(pins[0]),
    .second_command_terminal(pins[1]), .enable_terminal(pins[2]),
    .terminal_command_mode_setting(mode), .forward_run_command(fw), .reverse_run_command(rv));
  initial begin
    forever #25 clk = ~clk;
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // bits: enable, second, first; result {forward, reverse}
  task st(input logic [2:0] p, input logic [1:0] e);
    press = p;
    repeat (4) @(posedge clk);
    #5;
    check_count++;
    if ({fw, rv} !== e) begin
      error_cnt++;
      $display("MISMATCH run exp %h got %h", e, {fw, rv});
    end
  endtask
  task t_edge2;
    mode = 4'h2;
    st(3'h4, 2'h0);
    st(3'h5, 2'h2);
    st(3'h4, 2'h2);
    st(3'h6, 2'h1);
    st(3'h4, 2'h1);
    st(3'h5, 2'h2);
    st(3'h1, 2'h0);
    st(3'h0, 2'h0);
    st(3'h1, 2'h0);
    st(3'h5, 2'h0);
    $display("edge mode done");
  endtask
  task t_level3;
    mode = 4'h3;
    st(3'h4, 2'h0);
    st(3'h6, 2'h0);
    st(3'h7, 2'h1);
    st(3'h4, 2'h2);
    st(3'h0, 2'h0);
    $display("level direction mode done");
  endtask
  task t_prio4;
    mode = 4'h4;
    st(3'h1, 2'h2);
    st(3'h3, 2'h2);
    st(3'h2, 2'h1);
    st(3'h3, 2'h1);
    st(3'h0, 2'h0);
    $display("priority mode done");
  endtask
  task t_first5;
    mode = 4'h5;
    st(3'h4, 2'h0);
    st(3'h5, 2'h2);
    st(3'h7, 2'h2);
    st(3'h4, 2'h2);
    st(3'h6, 2'h1);
    st(3'h7, 2'h1);
    st(3'h3, 2'h0);
    $display("first wins mode done");
  endtask
  task t_modes;
    mode = 4'h0;
    st(3'h1, 2'h2);
    st(3'h3, 2'h0);
    mode = 4'h1;
    st(3'h3, 2'h1);
    st(3'h1, 2'h2);
    mode = 4'h7;
    st(3'h1, 2'h0);
    $display("mode select done");
  endtask
  task t_reset;
    mode = 4'h2;
    st(3'h4, 2'h0);
    st(3'h5, 2'h2);
    reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #5;
    reset_n = 1'b1;
    st(3'h5, 2'h0);
    st(3'h4, 2'h0);
    st(3'h5, 2'h2);
    $display("mid-run reset done");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      error_cnt++;
      give_verdict;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    #5 reset_n = 1'b1;
    st(3'h0, 2'h0);
    t_edge2;
    t_level3;
    t_prio4;
    t_first5;
    t_modes;
    t_reset;
    give_verdict;
  end
endmodule
`default_nettype wire
